// ---- power_on_timer.sv ----
// Power-on release timer for the warning flags
`timescale 1ns/1ns
`include "servo_flags_cfg.svh"

module power_on_timer #(
    parameter int unsigned CYCLES = `WARN_RELEASE_CYC
) (
    input  wire logic clk_in,   // Control clock
    input  wire logic rst_in,   // Power-on reset, async high
    output logic      done_out  // High once the release time has run
);
    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic [CW-1:0] count_r;
    logic          done_r;

    // Counter stops at the end so done never falls again
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            count_r <= '0;
            done_r  <= 1'b0;
        end
        else if (!done_r)
        begin
            count_r <= count_r + CW'(1);
            done_r  <= (count_r == CW'(CYCLES - 1));
        end
    end

    assign done_out = done_r;

    property p_done_sticky;
        @(posedge clk_in) disable iff (rst_in) done_r |=> done_r;
    endproperty
    a_done_sticky: assert property (p_done_sticky) else $error("Release timer dropped");

endmodule // power_on_timer

// ---- servo_flags_cfg.svh ----
// Constants for the servo status-flag block: widths, thresholds and timing
`ifndef SERVO_FLAGS_CFG_SVH
`define SERVO_FLAGS_CFG_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define SPEED_W              16
`define MAG_W                18
`define PROD_W               24

// ****************************************************************
// Speed thresholds (r/min, or mm/s for a linear motor)
// ****************************************************************
`define ATTAIN_RATIO_DEN     20
`define ATTAIN_OFFSET        20
`define ATTAIN_LOW_CMD       20
`define ZERO_SPEED_DEFAULT   50
`define ZERO_SPEED_HYST      20

// ****************************************************************
// Timing
// ****************************************************************
`define CLK_KHZ              125000
`define WARN_RELEASE_MIN_MS  2500
`define WARN_RELEASE_MAX_MS  3500
`define WARN_RELEASE_MS      ((`WARN_RELEASE_MIN_MS + `WARN_RELEASE_MAX_MS) / 2)
`define WARN_RELEASE_CYC     (`WARN_RELEASE_MS * `CLK_KHZ)

`endif

// ---- servo_flags_pkg.sv ----
// Types shared by the servo status-flag block
package servo_flags_pkg;
`include "servo_flags_cfg.svh"

    // Control mode of the amplifier; the fourth code is illegal
    typedef enum logic [1:0] {
        MODE_POSITION,
        MODE_VELOCITY,
        MODE_TORQUE
    } ctrl_mode_t;

    // One control-cycle sample of the motor state
    typedef struct packed {
        logic signed [`SPEED_W-1:0] speed;
        logic signed [`SPEED_W-1:0] cmd_speed;
        logic        [`SPEED_W-1:0] speed_limit;
        logic signed [`SPEED_W-1:0] torque;
        logic        [`SPEED_W-1:0] torque_limit;
    } motion_sample_t;

    // Discrete status outputs seen by the motion controller
    typedef struct packed {
        logic speed_attained_flag;
        logic speed_limit_active;
        logic zero_speed_flag;
        logic torque_limit_active;
        logic warning_flag;
        logic battery_warning_flag;
        logic gain_switch_active;
        logic abs_position_unknown;
        logic ride_through_active;
        logic full_closed_loop_active;
    } status_flags_t;

endpackage

// ---- servo_status_output_flags.sv ----
// Status-flag logic of a servo amplifier: speed, torque, warning and mode flags
`timescale 1ns/1ns
`include "servo_flags_cfg.svh"

module servo_status_output_flags #(
    parameter int unsigned WARN_RELEASE_CYCLES = `WARN_RELEASE_CYC
) (
    input  wire logic                           clk_in,                        // Control clock, 125 MHz
    input  wire logic                           rst_in,                        // Power-on reset, async high
    input  wire logic                           sample_in,                     // Control-cycle sample strobe
    input  wire servo_flags_pkg::ctrl_mode_t    mode_in,                       // Control mode
    input  wire servo_flags_pkg::motion_sample_t motion_in,                    // Motor state sample
    input  wire logic [`SPEED_W-1:0]            zero_speed_threshold_param_in, // Zero-speed level, 0 = default
    input  wire logic                           servo_on_in,                   // Servo-on state
    input  wire logic                           linear_motor_in,               // Linear motor is driven
    input  wire logic                           warning_active_in,             // Any warning active
    input  wire logic                           battery_cable_open_warning_in, // Battery cable open warning
    input  wire logic                           battery_low_warning_in,        // Battery low warning
    input  wire logic                           variable_gain_in,              // Variable gain in effect
    input  wire logic                           abs_undetermined_in,           // Absolute position undetermined
    input  wire logic                           ride_through_enable_param_in,  // Ride-through enabled
    input  wire logic                           power_fail_ride_in,            // Ride-through function acting
    input  wire logic                           full_closed_loop_in,           // Fully closed loop operating
    output servo_flags_pkg::status_flags_t      flags_out,                     // Discrete status flags
    output logic                                speed_unit_mm_s_out            // Speeds read in mm/s
);
    import servo_flags_pkg::*;

    // ****************************************************************
    // Arithmetic helpers
    // ****************************************************************

    // Magnitude of a sign-extended value
    function automatic logic [`MAG_W-1:0] mag(input logic signed [`MAG_W-1:0] v);
        return v[`MAG_W-1] ? `MAG_W'(-v) : `MAG_W'(v);
    endfunction

    // Sign extension of a speed-wide word to the magnitude width
    function automatic logic signed [`MAG_W-1:0] sext(input logic [`SPEED_W-1:0] v);
        return {{(`MAG_W-`SPEED_W){v[`SPEED_W-1]}}, v};
    endfunction

    // ****************************************************************
    // Mode decode and speed arithmetic
    // ****************************************************************

    logic                is_pos;
    logic                is_vel;
    logic                is_torq;
    logic [`MAG_W-1:0]   speed_mag;
    logic [`MAG_W-1:0]   cmd_mag;
    logic [`MAG_W-1:0]   err_mag;
    logic [`MAG_W-1:0]   torque_mag;
    logic [`MAG_W-1:0]   zero_on_lvl;
    logic [`MAG_W-1:0]   zero_off_lvl;
    logic [`PROD_W-1:0]  err_scaled;
    logic [`PROD_W-1:0]  band_scaled;

    // Illegal mode code enables no mode-bound flag except the torque limit, which is watched outside torque mode
    always_comb
    begin
        is_pos  = 1'b0;
        is_vel  = 1'b0;
        is_torq = 1'b0;
        unique case (mode_in)
            MODE_POSITION: is_pos  = 1'b1;
            MODE_VELOCITY: is_vel  = 1'b1;
            MODE_TORQUE:   is_torq = 1'b1;
            default:       is_pos  = 1'b0;
        endcase
    end

    // Magnitudes; the speed difference needs the extra bits
    assign speed_mag  = mag(sext(motion_in.speed));
    assign cmd_mag    = mag(sext(motion_in.cmd_speed));
    assign err_mag    = mag(sext(motion_in.speed) - sext(motion_in.cmd_speed));
    assign torque_mag = mag(sext(motion_in.torque));

    // Band scaled by 20 so that 5 percent stays exact, no rounding
    assign err_scaled  = `PROD_W'(err_mag) * `PROD_W'(`ATTAIN_RATIO_DEN);
    assign band_scaled = `PROD_W'(cmd_mag)
                       + `PROD_W'(`ATTAIN_OFFSET) * `PROD_W'(`ATTAIN_RATIO_DEN);

    // Units are whatever the speed sample carries, so one compare serves both motors
    assign zero_on_lvl  = (zero_speed_threshold_param_in == '0)
                        ? `MAG_W'(`ZERO_SPEED_DEFAULT)
                        : `MAG_W'(zero_speed_threshold_param_in);
    assign zero_off_lvl = zero_on_lvl + `MAG_W'(`ZERO_SPEED_HYST);

    // ****************************************************************
    // Speed and torque flags
    // ****************************************************************

    logic attain_r;
    logic attain_nxt;
    logic vlimit_r;
    logic vlimit_nxt;
    logic tlimit_r;
    logic tlimit_nxt;
    logic zero_r;
    logic zero_nxt;
    logic unit_mm_r;

    // Next values of the speed-derived flags
    always_comb
    begin
        attain_nxt = 1'b0;
        if (servo_on_in && is_vel)
            attain_nxt = (cmd_mag <= `MAG_W'(`ATTAIN_LOW_CMD))
                       || (err_scaled <= band_scaled);
        vlimit_nxt = servo_on_in && is_torq
                   && (speed_mag >= `MAG_W'(motion_in.speed_limit));
        tlimit_nxt = servo_on_in && !is_torq
                   && (torque_mag >= `MAG_W'(motion_in.torque_limit));
        if (zero_r)
            zero_nxt = (speed_mag < zero_off_lvl);
        else
            zero_nxt = (speed_mag <= zero_on_lvl);
    end

    // All speed flags move together on the sample edge
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            attain_r <= 1'b0;
            vlimit_r <= 1'b0;
            tlimit_r <= 1'b0;
            zero_r   <= 1'b0;
        end
        else if (sample_in)
        begin
            attain_r <= attain_nxt;
            vlimit_r <= vlimit_nxt;
            tlimit_r <= tlimit_nxt;
            zero_r   <= zero_nxt;
        end
    end

    // Unit indicator for the zero-speed levels
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
            unit_mm_r <= 1'b0;
        else if (sample_in)
            unit_mm_r <= linear_motor_in;
    end

    // ****************************************************************
    // Warning flags with power-on release
    // ****************************************************************

    logic release_done;
    logic warn_r;
    logic batt_r;

    power_on_timer #(
        .CYCLES   (WARN_RELEASE_CYCLES)
    ) u_release (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .done_out (release_done)
    );

    // Flags stand on through start-up so the controller sees no false clear
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            warn_r <= 1'b1;
            batt_r <= 1'b1;
        end
        else
        begin
            warn_r <= !release_done || warning_active_in;
            batt_r <= !release_done || battery_cable_open_warning_in
                    || battery_low_warning_in;
        end
    end

    // ****************************************************************
    // Operating-state flags
    // ****************************************************************

    logic gain_r;
    logic absu_r;
    logic ride_r;
    logic cloop_r;

    // Plain state flags, sampled with the speed flags
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            gain_r  <= 1'b0;
            absu_r  <= 1'b0;
            ride_r  <= 1'b0;
            cloop_r <= 1'b0;
        end
        else if (sample_in)
        begin
            gain_r  <= variable_gain_in;
            absu_r  <= is_pos && abs_undetermined_in;
            ride_r  <= ride_through_enable_param_in && power_fail_ride_in;
            cloop_r <= full_closed_loop_in;
        end
    end

    // Outputs are flops only; order follows status_flags_t, msb first
    assign flags_out = {attain_r, vlimit_r, zero_r, tlimit_r, warn_r,
                        batt_r, gain_r, absu_r, ride_r, cloop_r};
    assign speed_unit_mm_s_out = unit_mm_r;

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence s_vel_sample;
        sample_in && servo_on_in && (mode_in == MODE_VELOCITY);
    endsequence
    sequence s_off_sample;
        sample_in && !servo_on_in;
    endsequence
    sequence s_zero_set;
        sample_in && (speed_mag <= zero_on_lvl);
    endsequence

    property p_attain_band;
        s_vel_sample ##0 (20 * int'(err_mag) <= int'(cmd_mag) + 400) |=> attain_r;
    endproperty
    a_attain_band: assert property (p_attain_band) else $error("Speed in band but not attained");
    property p_attain_low;
        s_vel_sample ##0 (int'(cmd_mag) <= 20) |=> attain_r;
    endproperty
    a_attain_low: assert property (p_attain_low) else $error("Low command not attained");
    property p_attain_mode;
        sample_in && (mode_in != MODE_VELOCITY) |=> !attain_r;
    endproperty
    a_attain_mode: assert property (p_attain_mode) else $error("Attained outside velocity mode");
    property p_attain_off;
        s_off_sample |=> !attain_r && !vlimit_r && !tlimit_r;
    endproperty
    a_attain_off: assert property (p_attain_off) else $error("Flag stands at servo-off");

    property p_vlimit;
        sample_in && servo_on_in && (mode_in == MODE_TORQUE)
            && (speed_mag >= `MAG_W'(motion_in.speed_limit)) |=> vlimit_r;
    endproperty
    a_vlimit: assert property (p_vlimit) else $error("Speed limit not flagged");

    property p_vlimit_mode;
        sample_in && (mode_in != MODE_TORQUE) |=> !vlimit_r;
    endproperty
    a_vlimit_mode: assert property (p_vlimit_mode) else $error("Speed limit outside torque mode");

    property p_zero_on;
        s_zero_set |=> zero_r;
    endproperty
    a_zero_on: assert property (p_zero_on) else $error("Zero speed not flagged");
    property p_zero_hyst;
        zero_r && sample_in && (int'(speed_mag) < int'(zero_on_lvl) + 20) |=> zero_r;
    endproperty
    a_zero_hyst: assert property (p_zero_hyst) else $error("Zero speed released inside band");
    property p_zero_off;
        sample_in && (int'(speed_mag) >= int'(zero_on_lvl) + 20) |=> !zero_r;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("Zero speed kept above release");

    property p_tlimit;
        sample_in && (mode_in == MODE_TORQUE) |=> !tlimit_r;
    endproperty
    a_tlimit: assert property (p_tlimit) else $error("Torque limit in torque mode");

    property p_warn_hold;
        !release_done |=> warn_r && batt_r;
    endproperty
    a_warn_hold: assert property (p_warn_hold) else $error("Warning released early");

    property p_warn_follow;
        release_done && !warning_active_in |=> !warn_r;
    endproperty
    a_warn_follow: assert property (p_warn_follow) else $error("Warning flag not released");

    property p_batt;
        release_done ##0 (battery_cable_open_warning_in || battery_low_warning_in) |=> batt_r;
    endproperty
    a_batt: assert property (p_batt) else $error("Battery warning missed");
    property p_batt_off;
        release_done && !battery_cable_open_warning_in && !battery_low_warning_in |=> !batt_r;
    endproperty
    a_batt_off: assert property (p_batt_off) else $error("Battery flag not released");

    property p_state_flags;
        sample_in |=> (gain_r == $past(variable_gain_in))
                   && (ride_r == $past(ride_through_enable_param_in && power_fail_ride_in))
                   && (cloop_r == $past(full_closed_loop_in));
    endproperty
    a_state_flags: assert property (p_state_flags) else $error("State flag mismatch");

    property p_abs;
        sample_in && (mode_in != MODE_POSITION) |=> !absu_r;
    endproperty
    a_abs: assert property (p_abs) else $error("Abs unknown outside position mode");

    property p_hold;
        !sample_in |=> $stable({attain_r, vlimit_r, tlimit_r, zero_r});
    endproperty
    a_hold: assert property (p_hold) else $error("Speed flag moved without sample");

endmodule // servo_status_output_flags

// ---- servo_status_output_flags_tb_top.sv ----
// Self-checking testbench for the servo status-flag block
`timescale 1ns/1ns
module servo_status_output_flags_tb_top;
    import servo_flags_pkg::*;

    logic           clk_in, rst_in, sample_in, servo_on_in, linear_motor_in;
    logic           warning_active_in, battery_cable_open_warning_in, battery_low_warning_in;
    logic           variable_gain_in, abs_undetermined_in, ride_through_enable_param_in;
    logic           power_fail_ride_in, full_closed_loop_in, speed_unit_mm_s_out;
    ctrl_mode_t     mode_in;
    motion_sample_t motion_in;
    logic [15:0]    zero_speed_threshold_param_in, reads;
    status_flags_t  flags, seen;
    int             num_errors = 0;
    int             checked = 0;
    int             n_smp = 0;

    servo_status_output_flags #(.WARN_RELEASE_CYCLES(20)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .sample_in(sample_in), .mode_in(mode_in), .motion_in(motion_in),
        .zero_speed_threshold_param_in(zero_speed_threshold_param_in), .servo_on_in(servo_on_in),
        .linear_motor_in(linear_motor_in), .warning_active_in(warning_active_in),
        .battery_cable_open_warning_in(battery_cable_open_warning_in),
        .battery_low_warning_in(battery_low_warning_in), .variable_gain_in(variable_gain_in),
        .abs_undetermined_in(abs_undetermined_in), .ride_through_enable_param_in(ride_through_enable_param_in),
        .power_fail_ride_in(power_fail_ride_in), .full_closed_loop_in(full_closed_loop_in),
        .flags_out(flags), .speed_unit_mm_s_out(speed_unit_mm_s_out));

    status_reader reader (.clk_in(clk_in), .rst_in(rst_in), .sample_in(sample_in), .flags_in(flags),
        .seen_out(seen), .reads_out(reads));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One control-cycle sample; flags are settled on return
    task automatic smp(input logic [15:0] s, c, sl, t, tl);
        n_smp++;
        @(posedge clk_in);
        motion_in <= {s, c, sl, t, tl};
        sample_in <= 1'b1;
        @(posedge clk_in);
        sample_in <= 1'b0;
        #1;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic test_warning();
        repeat (3) @(posedge clk_in);
        #1;
        chk(flags.warning_flag, 1);
        chk(flags.battery_warning_flag, 1);
        repeat (25) @(posedge clk_in);
        #1;
        chk(flags.warning_flag, 0);
        chk(flags.battery_warning_flag, 0);
        @(posedge clk_in);
        warning_active_in <= 1'b1;
        battery_cable_open_warning_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk(flags.warning_flag, 1);
        chk(flags.battery_warning_flag, 1);
        @(posedge clk_in);
        warning_active_in <= 1'b0;
        battery_cable_open_warning_in <= 1'b0;
        battery_low_warning_in <= 1'b1;
        @(posedge clk_in);
        #1;
        chk(flags.warning_flag, 0);
        chk(flags.battery_warning_flag, 1);
        $display("test warning done");
    endtask

    task automatic test_attained();
        @(posedge clk_in);
        mode_in <= MODE_VELOCITY;
        servo_on_in <= 1'b1;
        smp(1070, 1000, 0, 0, 16'h7FFF); chk(flags.speed_attained_flag, 1);
        smp(1071, 1000, 0, 0, 16'h7FFF); chk(flags.speed_attained_flag, 0);
        smp(-930, -1000, 0, 0, 16'h7FFF); chk(flags.speed_attained_flag, 1);
        smp(-929, -1000, 0, 0, 16'h7FFF); chk(flags.speed_attained_flag, 0);
        smp(500, 20, 0, 0, 16'h7FFF); chk(flags.speed_attained_flag, 1);
        smp(500, 21, 0, 0, 16'h7FFF); chk(flags.speed_attained_flag, 0);
        @(posedge clk_in);
        mode_in <= MODE_POSITION;
        smp(1000, 1000, 0, 0, 16'h7FFF); chk(flags.speed_attained_flag, 0);
        @(posedge clk_in);
        mode_in <= MODE_VELOCITY;
        servo_on_in <= 1'b0;
        smp(1000, 1000, 0, 0, 16'h7FFF); chk(flags.speed_attained_flag, 0);
        $display("test attained done");
    endtask

    task automatic test_limits();
        @(posedge clk_in);
        mode_in <= MODE_TORQUE;
        servo_on_in <= 1'b1;
        smp(300, 0, 300, 900, 500); chk(flags.speed_limit_active, 1);
        chk(flags.torque_limit_active, 0);
        smp(299, 0, 300, 0, 500); chk(flags.speed_limit_active, 0);
        smp(-300, 0, 300, 0, 500); chk(flags.speed_limit_active, 1);
        @(posedge clk_in);
        servo_on_in <= 1'b0;
        smp(-300, 0, 300, 0, 500); chk(flags.speed_limit_active, 0);
        @(posedge clk_in);
        servo_on_in <= 1'b1;
        mode_in <= MODE_POSITION;
        smp(400, 0, 300, -500, 500); chk(flags.speed_limit_active, 0);
        chk(flags.torque_limit_active, 1);
        smp(400, 0, 300, 499, 500); chk(flags.torque_limit_active, 0);
        smp(400, 0, 300, 500, 500); chk(flags.torque_limit_active, 1);
        @(posedge clk_in);
        servo_on_in <= 1'b0;
        smp(400, 0, 300, 500, 500); chk(flags.torque_limit_active, 0);
        $display("test limits done");
    endtask

    task automatic test_zero();
        int   sp[8] = '{50, 69, 70, 60, -50, -69, -70, 51};
        logic ex[8] = '{1, 1, 0, 0, 1, 1, 0, 0};
        for (int i = 0; i < 8; i++)
        begin
            smp(16'(sp[i]), 0, 0, 0, 16'h7FFF);
            chk(flags.zero_speed_flag, ex[i]);
        end
        chk(speed_unit_mm_s_out, 0);
        @(posedge clk_in);
        zero_speed_threshold_param_in <= 16'h0064;
        linear_motor_in <= 1'b1;
        smp(100, 0, 0, 0, 16'h7FFF); chk(flags.zero_speed_flag, 1);
        chk(speed_unit_mm_s_out, 1);
        smp(119, 0, 0, 0, 16'h7FFF); chk(flags.zero_speed_flag, 1);
        smp(120, 0, 0, 0, 16'h7FFF); chk(flags.zero_speed_flag, 0);
        // Strobe low: a changed speed must not move the flag
        @(posedge clk_in);
        motion_in.speed <= 16'h0000;
        repeat (3) @(posedge clk_in);
        #1;
        chk(flags.zero_speed_flag, 0);
        chk(seen.zero_speed_flag, 0);
        chk(reads, 16'(n_smp));
        $display("test zero speed done");
    endtask

    task automatic test_misc();
        @(posedge clk_in);
        mode_in <= MODE_POSITION;
        variable_gain_in <= 1'b1;
        abs_undetermined_in <= 1'b1;
        ride_through_enable_param_in <= 1'b0;
        power_fail_ride_in <= 1'b1;
        full_closed_loop_in <= 1'b1;
        smp(0, 0, 0, 0, 16'h7FFF);
        chk(flags.gain_switch_active, 1);
        chk(flags.abs_position_unknown, 1);
        chk(flags.ride_through_active, 0);
        chk(flags.full_closed_loop_active, 1);
        @(posedge clk_in);
        mode_in <= MODE_VELOCITY;
        variable_gain_in <= 1'b0;
        ride_through_enable_param_in <= 1'b1;
        full_closed_loop_in <= 1'b0;
        smp(0, 0, 0, 0, 16'h7FFF);
        chk(flags.gain_switch_active, 0);
        chk(flags.abs_position_unknown, 0);
        chk(flags.ride_through_active, 1);
        chk(flags.full_closed_loop_active, 0);
        // Illegal mode code: no mode-bound flag, torque limit still watched
        @(posedge clk_in);
        mode_in <= ctrl_mode_t'(2'h3);
        servo_on_in <= 1'b1;
        smp(300, 0, 300, 500, 500);
        chk(flags.speed_attained_flag, 0);
        chk(flags.speed_limit_active, 0);
        chk(flags.abs_position_unknown, 0);
        chk(flags.torque_limit_active, 1);
        $display("test misc done");
    endtask

    // ****************************************************************
    // Clock, watchdog and main sequence
    // ****************************************************************
    initial
    begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end

    // Cuts a hang short
    initial
    begin
        repeat (100000) @(posedge clk_in);
        num_errors++;
        print_verdict();
    end

    initial
    begin
        {rst_in, sample_in, servo_on_in, linear_motor_in} = 4'h8;
        {warning_active_in, battery_cable_open_warning_in, battery_low_warning_in} = 3'h0;
        {variable_gain_in, abs_undetermined_in, ride_through_enable_param_in} = 3'h0;
        {power_fail_ride_in, full_closed_loop_in} = 2'h0;
        mode_in = MODE_VELOCITY;
        motion_in = '0;
        zero_speed_threshold_param_in = 16'h0000;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        test_warning();
        test_attained();
        test_limits();
        test_zero();
        test_misc();
        print_verdict();
    end
endmodule // servo_status_output_flags_tb_top

// ---- status_reader.sv ----
// Motion controller model that reads the discrete status outputs
`timescale 1ns/1ns
module status_reader (
    input  wire logic                          clk_in,    // Control clock
    input  wire logic                          rst_in,    // Reset, async high
    input  wire logic                          sample_in, // Control-cycle strobe
    input  wire servo_flags_pkg::status_flags_t flags_in, // Flags from the amplifier
    output servo_flags_pkg::status_flags_t     seen_out,  // Flags read last
    output logic [15:0]                        reads_out  // Reads taken
);
    import servo_flags_pkg::*;

    logic sample_d_r;

    // Read one cycle after each strobe, when the answer has landed
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sample_d_r <= 1'b0;
            seen_out   <= '0;
            reads_out  <= 16'h0000;
        end
        else
        begin
            sample_d_r <= sample_in;
            if (sample_d_r)
            begin
                seen_out  <= flags_in;
                reads_out <= reads_out + 16'h0001;
            end
        end
    end
endmodule // status_reader
